// ### fesh_pkg.sv
// Purpose: Constants for the flash erase/suspend host controller
// Assumes: 16-bit word-addressed parallel NOR flash, Avalon-MM command port
// Notes:   Command codes, unlock addresses, register map and strobe timing
package fesh_pkg;
  // Flash command addresses and data
  localparam logic [15:0] FESH_UNLOCK1_ADDR = 16'h0555; // First unlock address
  localparam logic [15:0] FESH_UNLOCK2_ADDR = 16'h02aa; // Second unlock address
  localparam logic [15:0] FESH_UNLOCK1_DATA = 16'h00aa; // First unlock data
  localparam logic [15:0] FESH_UNLOCK2_DATA = 16'h0055; // Second unlock data
  localparam logic [15:0] FESH_ERASE_SETUP  = 16'h0080; // Erase setup code
  localparam logic [15:0] FESH_CHIP_ERASE   = 16'h0010; // Chip erase code
  localparam logic [15:0] FESH_SECTOR_ERASE = 16'h0030; // Sector erase code
  localparam logic [15:0] FESH_SUSPEND      = 16'h00b0; // Erase suspend code
  localparam logic [15:0] FESH_RESUME       = 16'h0030; // Erase resume code
  localparam logic [15:0] FESH_QUERY_ADDR   = 16'h0055; // Overlay entry offset
  localparam logic [15:0] FESH_QUERY_ENTER  = 16'h0098; // Overlay entry code
  localparam logic [15:0] FESH_EXIT         = 16'h00f0; // Overlay exit code
  localparam logic [15:0] FESH_STATUS_ADDR  = 16'h0555; // Status read address
  localparam logic [15:0] FESH_STATUS_READ  = 16'h0070; // Status read code
  localparam logic [15:0] FESH_STATUS_CLEAR = 16'h0071; // Status clear code
  localparam logic [15:0] FESH_PROT_OFFSET  = 16'h0002; // Protection word offset
  // Status word bit positions
  localparam int FESH_SR_BUSY    = 7;
  localparam int FESH_SR_ESUSP   = 6;
  localparam int FESH_SR_EFAIL   = 5;
  localparam int FESH_SR_LOCKED  = 1;
  localparam int FESH_PROT_BIT   = 0;
  // Register map, byte addresses on Avalon
  localparam logic [3:0] FESH_REG_CMD    = 4'h0; // Command, write starts op
  localparam logic [3:0] FESH_REG_ADDR   = 4'h4; // Target flash word address
  localparam logic [3:0] FESH_REG_STATUS = 4'h8; // Controller status
  localparam logic [3:0] FESH_REG_RESULT = 4'hc; // Last word read from flash
  // Command codes written to FESH_REG_CMD
  localparam logic [2:0] FESH_OP_CHIP    = 3'h1;
  localparam logic [2:0] FESH_OP_SECTOR  = 3'h2;
  localparam logic [2:0] FESH_OP_SUSPEND = 3'h3;
  localparam logic [2:0] FESH_OP_RESUME  = 3'h4;
  localparam logic [2:0] FESH_OP_STATUS  = 3'h5;
  localparam logic [2:0] FESH_OP_PROT    = 3'h6;
  localparam logic [2:0] FESH_OP_HWRESET = 3'h7;
  localparam logic [2:0] FESH_OP_CLEAR   = 3'h0;
  // Strobe timing at 40 MHz
  localparam int FESH_CLK_MHZ      = 40;
  localparam int FESH_T_PULSE_NS   = 50;  // Least strobe low time
  localparam int FESH_T_RESET_NS   = 500; // Least hardware reset pulse
  localparam int FESH_T_RECOV_NS   = 35000; // Reset recovery time
  localparam int FESH_PULSE_CYC = (FESH_T_PULSE_NS * FESH_CLK_MHZ + 999) / 1000;
  localparam int FESH_RESET_CYC = (FESH_T_RESET_NS * FESH_CLK_MHZ + 999) / 1000;
  localparam int FESH_RECOV_CYC = (FESH_T_RECOV_NS * FESH_CLK_MHZ + 999) / 1000;
  // Controller phase
  typedef enum logic [2:0] {
    FESH_IDLE, FESH_DRIVE, FESH_STROBE, FESH_HOLD, FESH_RSTLOW, FESH_RECOVER
  } fesh_state_t;
endpackage : fesh_pkg

// ### fesh_host.sv
// Purpose: Host controller driving erase, suspend, resume and overlays on a NOR flash
// Assumes: Avalon-MM slave with waitrequest; flash pins synchronous to clock
// Notes:   One bus cycle per flash write or read, sequences from a small ROM
//
// Contract
// - Chip erase: six writes, busy follows
// - Sector erase: sixth write carries sector address
// - After abort host reissues whole erase sequence
// - Program failure: clear, then resume erase
// - New sector needs exit and reentry
// - Enter with 98h at 55h, exit F0h
// - Unlock: AA at 555, 55 at 2AA
// - Suspend B0h, resume 30h, address ignored
`timescale 1ns/10ps
module fesh_host
  import fesh_pkg::*;
#(
  parameter int ADDR_W    = 16,             // Flash word address width
  parameter int RECOV_CYC = FESH_RECOV_CYC  // Reset recovery count, shortenable
) (
  input  wire  logic              clock,
  input  wire  logic              rst,
  // Avalon-MM slave
  input  wire  logic [3:0]        avs_address,
  input  wire  logic              avs_read,
  input  wire  logic              avs_write,
  input  wire  logic [31:0]       avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // Flash pins
  output logic [ADDR_W-1:0]       flash_addr,
  input  wire  logic [15:0]       flash_dq_in,
  output logic [15:0]             flash_dq_out,
  output logic                    flash_dq_oe,
  output logic                    flash_ce_n,
  output logic                    flash_oe_n,
  output logic                    flash_we_n,
  output logic                    flash_reset_n,
  input  wire  logic              ready_busy_n
);
  localparam logic [2:0] STEP_LAST = 3'h5; // Index of sixth write

  // Mode the controller believes the device is in
  typedef enum logic [2:0] {
    FESH_M_READ, FESH_M_CHIP, FESH_M_SECTOR, FESH_M_SUSP, FESH_M_QUERY
  } fesh_mode_t;

  fesh_state_t       state_reg, state_next;     // Bus phase
  fesh_mode_t        mode_reg, mode_next;       // Device mode as tracked
  logic [2:0]        op_reg, op_next;           // Operation under way
  logic [2:0]        step_reg, step_next;       // Write index in sequence
  logic [15:0]       cnt_reg, cnt_next;         // Strobe/reset timer
  logic [ADDR_W-1:0] target_reg, target_next;   // Sector or word address
  logic [15:0]       result_reg, result_next;   // Last flash read
  logic              rejected_reg, rejected_next; // Last command refused
  logic              is_read_reg, is_read_next; // Current cycle is a read
  logic [ADDR_W-1:0] faddr_reg, faddr_next;
  logic [15:0]       fdq_reg, fdq_next;
  logic              foe_reg, foe_next;         // Data output enable
  // Strobes are held at pin level so each pin comes straight from its flop
  logic              ce_n_reg, ce_n_next;       // Chip select pin, active low
  logic              oe_n_reg, oe_n_next;       // Output enable pin, active low
  logic              we_n_reg, we_n_next;       // Write strobe pin, active low
  logic              frst_reg, frst_next;       // Reset pin level, low resets
  logic [31:0]       rdata_reg, rdata_next;
  logic              wait_reg, wait_next;
  logic [ADDR_W-1:0] seq_addr;                  // Address of this write
  logic [15:0]       seq_data;                  // Data of this write
  logic [2:0]        seq_last;                  // Last step of the sequence
  logic              allowed;                   // Command legal in this mode
  logic [2:0]        new_op;
  logic [15:0]       max_cnt;

  // Write sequence table: address and data per step of each operation
  always_comb begin
    seq_addr = '0;
    seq_data = '0;
    seq_last = '0;
    unique case (op_reg)
      FESH_OP_CHIP, FESH_OP_SECTOR: begin
        seq_last = STEP_LAST;
        unique case (step_reg)
          3'h0:    begin seq_addr = ADDR_W'(FESH_UNLOCK1_ADDR); seq_data = FESH_UNLOCK1_DATA; end
          3'h1:    begin seq_addr = ADDR_W'(FESH_UNLOCK2_ADDR); seq_data = FESH_UNLOCK2_DATA; end
          3'h2:    begin seq_addr = ADDR_W'(FESH_UNLOCK1_ADDR); seq_data = FESH_ERASE_SETUP; end
          3'h3:    begin seq_addr = ADDR_W'(FESH_UNLOCK1_ADDR); seq_data = FESH_UNLOCK1_DATA; end
          3'h4:    begin seq_addr = ADDR_W'(FESH_UNLOCK2_ADDR); seq_data = FESH_UNLOCK2_DATA; end
          default: begin
            // Sixth write picks chip or sector erase
            if (op_reg == FESH_OP_CHIP) begin
              seq_addr = ADDR_W'(FESH_UNLOCK1_ADDR);
              seq_data = FESH_CHIP_ERASE;
            end else begin
              seq_addr = target_reg;
              seq_data = FESH_SECTOR_ERASE;
            end
          end
        endcase
      end
      FESH_OP_SUSPEND: seq_data = FESH_SUSPEND;
      FESH_OP_RESUME:  seq_data = FESH_RESUME;
      FESH_OP_CLEAR: begin
        seq_addr = ADDR_W'(FESH_STATUS_ADDR);
        seq_data = FESH_STATUS_CLEAR;
      end
      FESH_OP_STATUS: begin
        // Step 0 latches status, step 1 reads it back and leaves the overlay
        seq_last = 3'h1;
        seq_addr = ADDR_W'(FESH_STATUS_ADDR);
        seq_data = FESH_STATUS_READ;
      end
      FESH_OP_PROT: begin
        // Enter with sector address, read offset 2, then exit
        seq_last = 3'h2;
        unique case (step_reg)
          3'h0:    begin seq_addr = target_reg | ADDR_W'(FESH_QUERY_ADDR); seq_data = FESH_QUERY_ENTER; end
          3'h1:    seq_addr = target_reg | ADDR_W'(FESH_PROT_OFFSET);
          default: seq_data = FESH_EXIT;
        endcase
      end
      default: ;
    endcase
  end

  // Command legality against the tracked device mode
  always_comb begin
    new_op  = avs_writedata[2:0];
    allowed = 1'b0;
    unique case (new_op)
      FESH_OP_HWRESET: allowed = 1'b1;
      FESH_OP_STATUS:  allowed = 1'b1;
      FESH_OP_CHIP, FESH_OP_SECTOR, FESH_OP_PROT:
        allowed = (mode_reg == FESH_M_READ);
      FESH_OP_SUSPEND: allowed = (mode_reg == FESH_M_SECTOR);
      FESH_OP_RESUME:  allowed = (mode_reg == FESH_M_SUSP);
      FESH_OP_CLEAR:   allowed = (mode_reg == FESH_M_READ) || (mode_reg == FESH_M_SUSP);
      default: ;
    endcase
  end

  // Main sequencer and bus slave
  always_comb begin
    state_next    = state_reg;
    mode_next     = mode_reg;
    op_next       = op_reg;
    step_next     = step_reg;
    cnt_next      = cnt_reg;
    target_next   = target_reg;
    result_next   = result_reg;
    rejected_next = rejected_reg;
    is_read_next  = is_read_reg;
    faddr_next    = faddr_reg;
    fdq_next      = fdq_reg;
    foe_next      = foe_reg;
    ce_n_next     = ce_n_reg;
    oe_n_next     = oe_n_reg;
    we_n_next     = we_n_reg;
    frst_next     = frst_reg;
    rdata_next    = rdata_reg;
    wait_next     = 1'b1;
    max_cnt       = 16'(FESH_PULSE_CYC - 1);
    // Device leaves erase on its own when ready rises (erase done; not while a suspend is under way)
    if ((mode_reg == FESH_M_CHIP || mode_reg == FESH_M_SECTOR) && ready_busy_n &&
        state_reg == FESH_IDLE && op_reg != FESH_OP_SUSPEND)
      mode_next = FESH_M_READ;
    unique case (state_reg)
      FESH_IDLE: begin
        // Registers answer in the cycle after the request is seen
        if ((avs_read || avs_write) && !wait_reg) begin
          wait_next = 1'b1;
        end else if (avs_read) begin
          wait_next = 1'b0;
          unique case (avs_address)
            FESH_REG_ADDR:   rdata_next = 32'(target_reg);
            FESH_REG_STATUS: rdata_next = {27'h0, rejected_reg, ready_busy_n, mode_reg};
            FESH_REG_RESULT: rdata_next = {16'h0, result_reg};
            default:         rdata_next = 32'h0;
          endcase
        end else if (avs_write) begin
          wait_next = 1'b0;
          if (avs_address == FESH_REG_ADDR)
            target_next = avs_writedata[ADDR_W-1:0];
          else if (avs_address == FESH_REG_CMD) begin
            rejected_next = !allowed;
            if (allowed) begin
              op_next   = new_op;
              step_next = '0;
              cnt_next  = '0;
              state_next = (new_op == FESH_OP_HWRESET) ? FESH_RSTLOW : FESH_DRIVE;
              frst_next  = (new_op != FESH_OP_HWRESET);
            end
          end
        end
      end
      FESH_DRIVE: begin
        // Present address and data one cycle before the strobe
        is_read_next = (op_reg == FESH_OP_STATUS && step_reg == 3'h1) ||
                       (op_reg == FESH_OP_PROT && step_reg == 3'h1);
        faddr_next = seq_addr;
        fdq_next   = seq_data;
        foe_next   = !is_read_next;
        ce_n_next  = 1'b0;
        state_next = FESH_STROBE;
      end
      FESH_STROBE: begin
        oe_n_next = !is_read_reg;
        we_n_next = is_read_reg;
        cnt_next = cnt_reg + 16'h1;
        if (cnt_reg == max_cnt) begin
          state_next = FESH_HOLD;
          cnt_next   = '0;
        end
      end
      FESH_HOLD: begin
        // Strobes rise here; the device acts on this edge
        if (is_read_reg)
          result_next = flash_dq_in;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        ce_n_next = 1'b1;
        foe_next  = 1'b0;
        if (step_reg == seq_last) begin
          state_next = FESH_IDLE;
          unique case (op_reg)
            FESH_OP_CHIP:    mode_next = FESH_M_CHIP;
            FESH_OP_SECTOR:  mode_next = FESH_M_SECTOR;
            FESH_OP_SUSPEND: mode_next = FESH_M_SUSP;
            FESH_OP_RESUME:  mode_next = FESH_M_SECTOR;
            default: ;
          endcase
          op_next = FESH_OP_CLEAR;
        end else begin
          step_next  = step_reg + 3'h1;
          state_next = FESH_DRIVE;
        end
      end
      FESH_RSTLOW: begin
        frst_next = 1'b0;
        cnt_next  = cnt_reg + 16'h1;
        if (cnt_reg == 16'(FESH_RESET_CYC - 1)) begin
          frst_next  = 1'b1;
          cnt_next   = '0;
          state_next = FESH_RECOVER;
        end
      end
      FESH_RECOVER: begin
        cnt_next = cnt_reg + 16'h1;
        if (cnt_reg == 16'(RECOV_CYC - 1)) begin
          mode_next  = FESH_M_READ;
          op_next    = FESH_OP_CLEAR;
          state_next = FESH_IDLE;
        end
      end
      default: state_next = FESH_IDLE;
    endcase
  end

  // Register all state
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg    <= FESH_IDLE;
      mode_reg     <= FESH_M_READ;
      op_reg       <= FESH_OP_CLEAR;
      step_reg     <= '0;
      cnt_reg      <= '0;
      target_reg   <= '0;
      result_reg   <= '0;
      rejected_reg <= 1'b0;
      is_read_reg  <= 1'b0;
      faddr_reg    <= '0;
      fdq_reg      <= '0;
      foe_reg      <= 1'b0;
      ce_n_reg     <= 1'b1;
      oe_n_reg     <= 1'b1;
      we_n_reg     <= 1'b1;
      frst_reg     <= 1'b1;
      rdata_reg    <= '0;
      wait_reg     <= 1'b1;
    end else begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      op_reg       <= op_next;
      step_reg     <= step_next;
      cnt_reg      <= cnt_next;
      target_reg   <= target_next;
      result_reg   <= result_next;
      rejected_reg <= rejected_next;
      is_read_reg  <= is_read_next;
      faddr_reg    <= faddr_next;
      fdq_reg      <= fdq_next;
      foe_reg      <= foe_next;
      ce_n_reg     <= ce_n_next;
      oe_n_reg     <= oe_n_next;
      we_n_reg     <= we_n_next;
      frst_reg     <= frst_next;
      rdata_reg    <= rdata_next;
      wait_reg     <= wait_next;
    end
  end

  // Outputs straight from flops
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign flash_addr      = faddr_reg;
  assign flash_dq_out    = fdq_reg;
  assign flash_dq_oe     = foe_reg;
  assign flash_ce_n      = ce_n_reg;
  assign flash_oe_n      = oe_n_reg;
  assign flash_we_n      = we_n_reg;
  assign flash_reset_n   = frst_reg;
endmodule : fesh_host

// ### fesh_flash_model.sv
// Purpose: Behavioural flash partner for the erase/suspend host
// Assumes: Pins change on clock edges; sector is address bits 15:12
// Notes:   Erase and suspend times shortened by parameters
`timescale 1ns/10ps
module fesh_flash_model
  import fesh_pkg::*;
#(
  parameter int         ERASE_CYC = 200,  // Erase duration
  parameter int         SUSP_CYC  = 5,    // Suspend latency
  parameter logic [3:0] LOCK_SEC  = 4'h3  // Locked sector
) (
  input  wire logic        clock,
  input  wire logic [15:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_reset_n,
  output logic      [15:0] flash_dq_in,
  output logic             ready_busy_n
);
  logic [4:0][15:0] hist = '0;           // Last five written words
  logic [15:0] wa, wd, sr, last = '0;    // Write capture, status, bus
  logic [15:0] erased = '0;              // Erased flag per sector
  logic [3:0]  esec, qsec;               // Erasing and queried sector
  logic        busy = 0, chip = 0, susp = 0, stov = 0, qov = 0;
  logic        we_q = 1, oe_q = 1;
  int          tmr = 0, sp = 0;
  wire seq = hist == {FESH_UNLOCK1_DATA, FESH_UNLOCK2_DATA, FESH_ERASE_SETUP,
                      FESH_UNLOCK1_DATA, FESH_UNLOCK2_DATA};
  // Upper byte varies so the host must ignore it
  wire [15:0] status = {tmr[7:0], busy && !susp, susp, 6'h00};
  // Busy shows in the very cycle the starting write strobe rises, not one later
  wire kick = !we_q && flash_we_n && wd != FESH_STATUS_READ &&
              (susp ? wd == FESH_RESUME :
                      !busy && seq && (wd == FESH_CHIP_ERASE || wd == FESH_SECTOR_ERASE));
  // Commands act on the rising write strobe
  always @(posedge clock) begin
    we_q <= flash_we_n;
    oe_q <= flash_oe_n;
    if (!flash_we_n && !flash_ce_n) begin
      wa <= flash_addr;
      wd <= flash_dq_out;
    end
    if (!flash_oe_n && !flash_ce_n) last <= flash_dq_in;
    if (!oe_q && flash_oe_n) stov <= 0;
    if (sp == 1) susp <= 1;
    if (sp > 0) sp <= sp - 1;
    if (busy && !susp && tmr > 0) tmr <= tmr - 1;
    if (busy && !susp && tmr == 1) begin
      busy <= 0;
      erased <= erased | (chip ? ~(16'h1 << LOCK_SEC) : 16'h1 << esec);
    end
    if (!we_q && flash_we_n) begin
      hist <= {hist[3:0], wd};
      if (wd == FESH_STATUS_READ) begin
        stov <= 1;
        sr <= status;
      end else if (busy && !susp) begin
        if (wd == FESH_SUSPEND && !chip) sp <= SUSP_CYC;
      end else if (susp) begin
        // Any other accepted write leaves the erase suspended
        if (wd == FESH_RESUME) susp <= 0;
      end else if (seq && (wd == FESH_CHIP_ERASE || wd == FESH_SECTOR_ERASE)) begin
        busy <= 1;
        chip <= wd == FESH_CHIP_ERASE;
        esec <= wa[15:12];
        tmr <= ERASE_CYC;
      end else if (wd == FESH_QUERY_ENTER && wa[7:0] == 8'h55) begin
        qov <= 1;
        qsec <= wa[15:12];
      end else if (wd == FESH_EXIT) qov <= 0;
    end
    if (!flash_reset_n) begin
      busy <= 0;
      susp <= 0;
      sp <= 0;
      stov <= 0;
      qov <= 0;
    end
  end
  // Released or undefined reads show the inverse of the last value
  always_comb begin
    if (flash_ce_n || flash_oe_n) flash_dq_in = ~last;
    else if (stov) flash_dq_in = sr;
    else if (qov) flash_dq_in = (flash_addr[15:12] == qsec && flash_addr[11:0] == 12'h002) ?
                                {15'h0000, qsec == LOCK_SEC} : ~last;
    else if (busy && (!susp || flash_addr[15:12] == esec)) flash_dq_in = ~last;
    else flash_dq_in = erased[flash_addr[15:12]] ? 16'hffff : 16'h0000;
  end
  assign ready_busy_n = !(busy && !susp) && !kick;
endmodule : fesh_flash_model

// ### fesh_host_properties.sv
// Purpose: Concurrent checks on the host controller's flash pins and Avalon waitrequest
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every fesh_host instance
`timescale 1ns/10ps
module fesh_host_props
  import fesh_pkg::*;
#(
  parameter int ADDR_W = 16  // Flash word address width
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              avs_waitrequest,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0]       flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n,
  input wire logic              flash_reset_n
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] prev_reg;  // Data of the previous flash write
  // Remember each write so sequence order can be checked
  always_ff @(posedge clock) begin
    if (rst) prev_reg <= 16'h0000;
    else if ($fell(flash_we_n)) prev_reg <= flash_dq_out;
  end
  a_we_width: assert property ($fell(flash_we_n) |-> ##1 !flash_we_n ##1 flash_we_n)
    else $error("Write strobe width wrong");
  a_we_drive: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("Write without select or data");
  a_read_release: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("Data driven during read");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Answer longer than one cycle");
  a_reset_pulse: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*8])
    else $error("Reset pulse too short");
  a_chip_order: assert property ($fell(flash_we_n) && flash_dq_out == FESH_CHIP_ERASE
    |-> prev_reg == FESH_UNLOCK2_DATA && flash_addr == ADDR_W'(FESH_UNLOCK1_ADDR))
    else $error("Chip erase code out of order");
  a_unlock_addr: assert property ($fell(flash_we_n) && flash_dq_out == FESH_UNLOCK2_DATA
    |-> flash_addr == ADDR_W'(FESH_UNLOCK2_ADDR))
    else $error("Second unlock at wrong address");
  a_query_addr: assert property ($fell(flash_we_n) && flash_dq_out == FESH_QUERY_ENTER
    |-> flash_addr[7:0] == FESH_QUERY_ADDR[7:0])
    else $error("Query entry at wrong offset");
  c_hw_reset: cover property ($fell(flash_reset_n));
  c_suspend: cover property ($fell(flash_we_n) && flash_dq_out == FESH_SUSPEND);
  c_query: cover property ($fell(flash_we_n) && flash_dq_out == FESH_QUERY_ENTER);
endmodule : fesh_host_props
bind fesh_host fesh_host_props #(.ADDR_W(ADDR_W)) u_fesh_host_props (.*);

// ### tb_top.sv
// Purpose: Self-checking bench for the flash erase/suspend host
// Assumes: Flash partner model on the pins, Avalon register tasks
// Notes:   Recovery and erase counts shortened for a quick run
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top
  import fesh_pkg::*;
;
  logic        clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, flash_dq_oe, flash_ce_n, flash_oe_n;
  logic        flash_we_n, flash_reset_n, ready_busy_n;
  logic [15:0] flash_addr, flash_dq_in, flash_dq_out;
  int          num_errors = 0, n_tests = 0;
  always #12.5 clock = ~clock;
  fesh_host #(.RECOV_CYC(4)) u_fesh_host (.*);
  fesh_flash_model u_fesh_flash_model (.*);
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 3000);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
    if (n >= 3000) begin
      num_errors++;
      close_out();
    end
  endtask : bus
  task automatic cmd(input logic [2:0] c);
    bus(1'b1, FESH_REG_CMD, {29'h0, c});
  endtask : cmd
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Poll the tracked mode, bounded
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    do begin
      rd(FESH_REG_STATUS);
      n++;
    end while (q[2:0] !== m && n < 200);
    `CHK(q[2:0], m)
  endtask : wait_mode
  // Poll until the device reports ready, bounded by a few reads
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      rd(FESH_REG_STATUS);
      n++;
    end while (q[3] !== 1'b1 && n < 4);
  endtask : wait_ready
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(FESH_REG_STATUS); `CHK(q[4:0], 5'h08)
    rd(4'h2); `CHK(q, 32'h0)
    // Sector erase, suspend, refused commands, resume
    bus(1'b1, FESH_REG_ADDR, 32'h5000);
    cmd(FESH_OP_SECTOR); rd(FESH_REG_STATUS); `CHK(q[3:0], 4'h2)
    cmd(FESH_OP_SUSPEND); wait_mode(3'h3); wait_ready();
    rd(FESH_REG_STATUS); `CHK(q[3], 1'b1)
    cmd(FESH_OP_PROT); rd(FESH_REG_STATUS); `CHK(q[4], 1'b1)
    cmd(FESH_OP_CHIP); rd(FESH_REG_STATUS); `CHK(q[4], 1'b1)
    cmd(FESH_OP_CLEAR); rd(FESH_REG_STATUS); `CHK(q[4:0], 5'h0b)
    cmd(FESH_OP_STATUS); rd(FESH_REG_RESULT); `CHK(q[7:0], 8'h40)
    cmd(FESH_OP_RESUME); rd(FESH_REG_STATUS); `CHK(q[2:0], 3'h2)
    wait_mode(3'h0); `CHK(u_fesh_flash_model.erased, 16'h0020)
    // Hardware reset aborts, then the erase is issued again
    bus(1'b1, FESH_REG_ADDR, 32'h6000);
    cmd(FESH_OP_SECTOR); cmd(FESH_OP_HWRESET); wait_mode(3'h0);
    `CHK(u_fesh_flash_model.erased[6], 1'b0)
    cmd(FESH_OP_SECTOR); wait_mode(3'h0); `CHK(u_fesh_flash_model.erased[6], 1'b1)
    // Chip erase refuses suspend and skips the locked sector
    cmd(FESH_OP_CHIP); cmd(FESH_OP_SUSPEND);
    rd(FESH_REG_STATUS); `CHK(q[4:0], 5'h11)
    cmd(FESH_OP_STATUS); rd(FESH_REG_RESULT); `CHK(q[7:0], 8'h80)
    wait_mode(3'h0); `CHK(u_fesh_flash_model.erased, 16'hfff7)
    // Protection query of a locked then an open sector
    for (int s = 3; s < 6; s += 2) begin
      bus(1'b1, FESH_REG_ADDR, {16'h0, 4'(s), 12'h000});
      cmd(FESH_OP_PROT); rd(FESH_REG_RESULT); `CHK(q[0], s == 3)
    end
    close_out();
  end
endmodule : tb_top
